// ==== verilog/irq_defines.vh ====
// Offsets, field positions and reset values of the prioritized interrupt controller
`ifndef IRQ_DEFINES_VH
`define IRQ_DEFINES_VH
`define OFS_MAIN 8'h00
`define OFS_EDGE 8'h04
`define OFS_EXTP 8'h08
`define OFS_CTRL 8'h0c
`define OFS_PORT 8'h10
`define OFS_STAT 8'h14
`define RST_MAIN 8'h00
`define RST_EDGE 8'hf5
`define RST_EXTP 8'hc0
`define MASK_EDGE 8'hf5
`define MASK_EXTP 8'hdb
`define B_GIEH 7
`define B_GIEL 6
`define B_T0E 5
`define B_I0E 4
`define B_PCE 3
`define B_T0F 2
`define B_I0F 1
`define B_PCF 0
`define B_PUDIS 7
`define B_EDG0 6
`define B_EDG1 5
`define B_EDG2 4
`define B_T0P 2
`define B_PCP 0
`define B_I2P 7
`define B_I1P 6
`define B_I2E 4
`define B_I1E 3
`define B_I2F 1
`define B_I1F 0
`define B_PRION 0
`define VEC_HIGH 16'h0008
`define VEC_LOW 16'h0018
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11
`endif

// ==== verilog/prioritized_interrupt_control.v ====
// Two-level prioritized interrupt controller with AXI4-Lite register access
// Function
// RULE1: Taking an interrupt clears the global enable that allowed it.
// RULE2: With priorities on, an enabled high request preempts a low service routine.
// RULE3: Low requests stay pending while a high service routine runs.
// RULE4: On taking, push return address and load PC with 0008h or 0018h.
// RULE5: Return-from-service sets the single, high or low global enable again.
// RULE6: Pin and port-change events vector within three to four cycles; here vector_load rises five clocks after the pin changes.
// RULE7: Flags set on their condition regardless of any enable.
// RULE8: Main bit 7 is the global enable, or high enable with priorities.
// RULE9: Main bit 6 is the peripheral enable, or low enable with priorities.
// RULE10: Without priorities peripherals also need the peripheral enable.
// RULE11: Priority bits matter only when the priority feature is on.
// RULE12: Main register holds timer, pin 0, port-change enables and flags.
// RULE13: Port-change flag keeps setting while mismatch lasts; a port read ends it.
// RULE14: Port-change interrupt needs the changing pin's own change enable.
// RULE15: Edge-select bits 6,5,4 pick rising (1) or falling (0) edge.
// RULE16: Priority bits for timer, port change, pin 2 and pin 1; 1 is high.
// RULE17: Third register holds pin 2 and pin 1 enables and flags.
// RULE18: Unimplemented bits of second and third registers read as zero.
// RULE19: Bit 7 of second register disables all port-B pull-ups when set.
// RULE20: Software clears serviced flags before enabling interrupts again.
// RULE21: Software avoids memory-to-memory moves on control registers while enabled.
// RULE22: External pin 0 is always high priority.
// RULE23: With the priority feature off every interrupt vectors to 0008h.
// RULE24: Setting the priority enable bit turns on two-level priority.
// RULE25: High and low pending together vector to the high address first.
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "irq_defines.vh"

module prioritized_interrupt_control (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire ext_pin_zero,
  input wire ext_pin_one,
  input wire ext_pin_two,
  input wire [7:0] port_pins,
  input wire timer_zero_overflow,
  input wire [7:0] periph_pending,
  input wire [7:0] periph_prio,
  input wire return_from_service_instr,
  input wire [7:0] port_b_pin_pullup_enable,
  input wire [7:0] port_b_dir_input,
  output reg [7:0] port_b_pullup_on,
  output reg vector_load,
  output reg push_return,
  output reg [15:0] vector_addr
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers: change counts once stages two and three agree

reg [10:0] sync1_q;
reg [10:0] sync2_q;
reg [10:0] sync3_q;
reg [10:0] filt_q;
wire [10:0] agree = ~(sync2_q ^ sync3_q);
wire [10:0] filt_d = (agree & sync3_q) | (~agree & filt_q);

always @(posedge aclk) begin
  if (!aresetn) begin
    sync1_q <= 11'h000;
    sync2_q <= 11'h000;
    sync3_q <= 11'h000;
  end else begin
    sync1_q <= {port_pins, ext_pin_two, ext_pin_one, ext_pin_zero};
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
  end
end

// Filtered level moves only when two stages agree, so a one-cycle glitch never counts
always @(posedge aclk) begin
  if (!aresetn) begin
    filt_q <= 11'h000;
  end else begin
    filt_q <= filt_d;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Registers

reg [7:0] main_q;
reg [7:0] edge_q;
reg [7:0] extp_q;
reg prio_on_q;
reg [7:0] pin_chg_en_q;
reg [7:0] port_seen_q;
reg in_high_q;
reg in_low_q;

wire pudis = edge_q[`B_PUDIS];
wire pri = prio_on_q;

// Edge detect honours the selected polarity
function edge_hit;
  input old_v;
  input new_v;
  input rising;
  begin
    edge_hit = rising ? (~old_v & new_v) : (old_v & ~new_v);
  end
endfunction

wire hit0 = edge_hit(filt_q[0], filt_d[0], edge_q[`B_EDG0]); // [RULE15]
wire hit1 = edge_hit(filt_q[1], filt_d[1], edge_q[`B_EDG1]); // [RULE15]
wire hit2 = edge_hit(filt_q[2], filt_d[2], edge_q[`B_EDG2]); // [RULE15]
// Mismatch persists until the port is read, so the flag keeps re-setting
wire mismatch = |((filt_d[10:3] ^ port_seen_q) & pin_chg_en_q); // [RULE13] [RULE14]

////////////////////////////////////////////////////////////////////////////////
// Request and vector selection

wire t0_act = main_q[`B_T0E] & main_q[`B_T0F];
wire i0_act = main_q[`B_I0E] & main_q[`B_I0F];
wire pc_act = main_q[`B_PCE] & main_q[`B_PCF];
wire i1_act = extp_q[`B_I1E] & extp_q[`B_I1F];
wire i2_act = extp_q[`B_I2E] & extp_q[`B_I2F];
wire per_any = |periph_pending;

// Pin 0 has no priority bit and always counts as high
reg hi_pend;
reg lo_pend;
always @* begin
  hi_pend = i0_act; // [RULE22]
  lo_pend = 1'b0;
  if (edge_q[`B_T0P]) hi_pend = hi_pend | t0_act; // [RULE16]
  else lo_pend = lo_pend | t0_act; // [RULE16]
  if (edge_q[`B_PCP]) hi_pend = hi_pend | pc_act; // [RULE16]
  else lo_pend = lo_pend | pc_act; // [RULE16]
  if (extp_q[`B_I1P]) hi_pend = hi_pend | i1_act; // [RULE16]
  else lo_pend = lo_pend | i1_act; // [RULE16]
  if (extp_q[`B_I2P]) hi_pend = hi_pend | i2_act; // [RULE16]
  else lo_pend = lo_pend | i2_act; // [RULE16]
  // The class is only looked at when the priority feature is on
  hi_pend = hi_pend | (|(periph_pending & periph_prio)); // [RULE11]
  lo_pend = lo_pend | (|(periph_pending & ~periph_prio)); // [RULE11]
end
wire core_any = t0_act | i0_act | pc_act | i1_act | i2_act;

wire gieh = main_q[`B_GIEH];
wire giel = main_q[`B_GIEL];
wire req_compat = ~pri & gieh & (core_any | (giel & per_any)); // [RULE8] [RULE9] [RULE10]
// High needs only its own enable, so it preempts a running low routine
wire req_hi = pri & gieh & hi_pend; // [RULE2] [RULE8]
wire req_lo = pri & gieh & giel & lo_pend & ~in_high_q; // [RULE3] [RULE9]
reg take;
reg take_lo;
always @* begin
  take = 1'b0;
  take_lo = 1'b0;
  // No take in the cycle after a take, so each event loads one vector
  if (!vector_load) begin
    if (req_compat) take = 1'b1;
    else if (req_hi) take = 1'b1; // [RULE2]
    else if (req_lo) begin
      take = 1'b1;
      take_lo = 1'b1; // [RULE25]
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave: write waits for address and data together

wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
assign s_axi_awready = wr_go;
assign s_axi_wready = wr_go;
assign s_axi_arready = ~s_axi_rvalid;
wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
wire wb0 = wr_go & s_axi_wstrb[0];
wire wb1 = wr_go & s_axi_wstrb[1];
wire [7:0] wd = s_axi_wdata[7:0];
wire wr_main = wb0 & (s_axi_awaddr == `OFS_MAIN);
wire wr_edge = wb0 & (s_axi_awaddr == `OFS_EDGE);
wire wr_extp = wb0 & (s_axi_awaddr == `OFS_EXTP);
wire wr_ctl0 = wb0 & (s_axi_awaddr == `OFS_CTRL);
wire wr_ctl1 = wb1 & (s_axi_awaddr == `OFS_CTRL);
wire rd_port = rd_go & (s_axi_araddr == `OFS_PORT);

function mapped;
  input [7:0] a;
  begin
    mapped = (a == `OFS_MAIN) | (a == `OFS_EDGE) | (a == `OFS_EXTP) |
      (a == `OFS_CTRL) | (a == `OFS_PORT) | (a == `OFS_STAT);
  end
endfunction

wire t0_ovf_set = timer_zero_overflow;

// Hardware set wins over a software clear of the same flag
reg [7:0] main_d;
always @* begin
  main_d = wr_main ? wd : main_q;
  if (t0_ovf_set) main_d[`B_T0F] = 1'b1; // [RULE7]
  if (hit0) main_d[`B_I0F] = 1'b1; // [RULE7]
  if (mismatch) main_d[`B_PCF] = 1'b1; // [RULE7] [RULE13]
  if (return_from_service_instr) begin
    if (!pri || in_high_q || !in_low_q) main_d[`B_GIEH] = 1'b1; // [RULE5]
    else main_d[`B_GIEL] = 1'b1; // [RULE5]
  end
  if (take) begin
    if (take_lo) main_d[`B_GIEL] = 1'b0; // [RULE1]
    else main_d[`B_GIEH] = 1'b0; // [RULE1]
  end
end

reg [7:0] extp_d;
always @* begin
  extp_d = wr_extp ? (wd & `MASK_EXTP) : extp_q; // [RULE17] [RULE18]
  if (hit1) extp_d[`B_I1F] = 1'b1; // [RULE7]
  if (hit2) extp_d[`B_I2F] = 1'b1; // [RULE7]
end

always @(posedge aclk) begin
  if (!aresetn) begin
    main_q <= `RST_MAIN;
  end else begin
    main_q <= main_d; // [RULE12]
  end
end

always @(posedge aclk) begin
  if (!aresetn) begin
    extp_q <= `RST_EXTP;
  end else begin
    extp_q <= extp_d;
  end
end

always @(posedge aclk) begin
  if (!aresetn) begin
    edge_q <= `RST_EDGE;
  end else if (wr_edge) begin
    edge_q <= wd & `MASK_EDGE; // [RULE18]
  end
end

always @(posedge aclk) begin
  if (!aresetn) begin
    prio_on_q <= 1'b0;
  end else if (wr_ctl0) begin
    prio_on_q <= wd[`B_PRION]; // [RULE24]
  end
end

always @(posedge aclk) begin
  if (!aresetn) begin
    pin_chg_en_q <= 8'h00;
  end else if (wr_ctl1) begin
    pin_chg_en_q <= s_axi_wdata[15:8]; // [RULE14]
  end
end

// Snapshot taken on a port read is what ends a standing mismatch
always @(posedge aclk) begin
  if (!aresetn) begin
    port_seen_q <= 8'h00;
  end else if (rd_port) begin
    port_seen_q <= filt_q[10:3]; // [RULE13]
  end
end

////////////////////////////////////////////////////////////////////////////////
// Vectoring and service tracking

always @(posedge aclk) begin
  if (!aresetn) begin
    vector_load <= 1'b0;
    push_return <= 1'b0;
    vector_addr <= 16'h0000;
  end else begin
    vector_load <= take; // [RULE6]
    push_return <= take; // [RULE4]
    if (take) begin
      vector_addr <= take_lo ? `VEC_LOW : `VEC_HIGH; // [RULE4] [RULE23]
    end
  end
end

// Service levels are dropped outright while priorities are off
always @(posedge aclk) begin
  if (!aresetn) begin
    in_high_q <= 1'b0;
    in_low_q <= 1'b0;
  end else if (!pri) begin
    in_high_q <= 1'b0;
    in_low_q <= 1'b0;
  end else if (take) begin
    if (take_lo) in_low_q <= 1'b1;
    else in_high_q <= 1'b1;
  end else if (return_from_service_instr) begin
    if (in_high_q) in_high_q <= 1'b0; // [RULE5]
    else in_low_q <= 1'b0; // [RULE5]
  end
end

////////////////////////////////////////////////////////////////////////////////
// Pull-ups and bus answers

always @(posedge aclk) begin
  if (!aresetn) begin
    port_b_pullup_on <= 8'h00;
  end else begin
    port_b_pullup_on <= pudis ? 8'h00 : (port_b_pin_pullup_enable & port_b_dir_input); // [RULE19]
  end
end

reg [31:0] rd_mux;
always @* begin
  rd_mux = 32'h0000_0000;
  case (s_axi_araddr)
    `OFS_MAIN: rd_mux = {24'h000000, main_q};
    `OFS_EDGE: rd_mux = {24'h000000, edge_q}; // [RULE18]
    `OFS_EXTP: rd_mux = {24'h000000, extp_q}; // [RULE18]
    `OFS_CTRL: rd_mux = {16'h0000, pin_chg_en_q, 7'h00, prio_on_q};
    `OFS_PORT: rd_mux = {24'h000000, filt_q[10:3]};
    `OFS_STAT: rd_mux = {vector_addr, 14'h0000, in_low_q, in_high_q};
    default: rd_mux = 32'h0000_0000;
  endcase
end

always @(posedge aclk) begin
  if (!aresetn) begin
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `RESP_OKAY;
  end else if (wr_go) begin
    s_axi_bvalid <= 1'b1;
    s_axi_bresp <= mapped(s_axi_awaddr) ? `RESP_OKAY : `RESP_DECERR;
  end else if (s_axi_bready) begin
    s_axi_bvalid <= 1'b0;
  end
end

always @(posedge aclk) begin
  if (!aresetn) begin
    s_axi_rvalid <= 1'b0;
    s_axi_rresp <= `RESP_OKAY;
  end else if (rd_go) begin
    s_axi_rvalid <= 1'b1;
    s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_DECERR;
  end else if (s_axi_rready) begin
    s_axi_rvalid <= 1'b0;
  end
end

// Read data is captured once and then stands until rready
always @(posedge aclk) begin
  if (!aresetn) begin
    s_axi_rdata <= 32'h0000_0000;
  end else if (rd_go) begin
    s_axi_rdata <= rd_mux;
  end
end

endmodule // prioritized_interrupt_control

// ==== verification/irq_chk.sv ====
// Port-level assertion checker for the interrupt controller
`timescale 1ns/10ps
`include "irq_defines.vh"
module irq_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_wvalid,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire vector_load,
  input wire push_return,
  input wire [15:0] vector_addr
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  vec_pair_a: assert property (vector_load == push_return)
    else $error("push and load differ");
  vec_addr_a: assert property (vector_load |->
    (vector_addr == `VEC_HIGH || vector_addr == `VEC_LOW)) else $error("bad vector");
  no_retake_a: assert property (vector_load |=> !vector_load)
    else $error("take right after take");
  vec_hold_a: assert property (!vector_load |-> $stable(vector_addr))
    else $error("vector moved without load");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("no write response");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready wrong");
endmodule // irq_chk
bind prioritized_interrupt_control irq_chk irq_chk_inst (.*);

// ==== verification/core_model.sv ====
// Core model: enters a routine on each vector load, returns svc_len+1 cycles after it sees the load
`timescale 1ns/10ps
module core_model (
  input wire aclk,
  input wire aresetn,
  input wire vector_load,
  input wire [7:0] svc_len,
  output reg return_from_service_instr
);
  reg [7:0] cnt_q;
  reg [3:0] depth_q;
  always @(posedge aclk) begin
    return_from_service_instr <= 1'h0;
    if (!aresetn) begin
      cnt_q <= 8'h00;
      depth_q <= 4'h0;
    end else if (vector_load) begin
      cnt_q <= 8'h00;
      depth_q <= depth_q + 4'h1;
    end else if (depth_q != 4'h0) begin
      cnt_q <= cnt_q + 8'h01;
      if (cnt_q == svc_len) begin
        // Nested routines unwind one level per return
        return_from_service_instr <= 1'h1;
        depth_q <= depth_q - 4'h1;
        cnt_q <= 8'h00;
      end
    end
  end
endmodule // core_model

// ==== verification/testbench.sv ====
// Self-checking bench for the prioritized interrupt controller
`timescale 1ns/10ps
`include "irq_defines.vh"
module testbench;
  reg aclk = 1'h0;
  reg aresetn = 1'h0;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, svc_len = 8'h28;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, timer_zero_overflow = 1'h0;
  reg ext_pin_zero = 1'h0, ext_pin_one = 1'h0, ext_pin_two = 1'h0;
  reg [7:0] port_pins = 8'h00, periph_pending = 8'h00, periph_prio = 8'h00;
  reg [7:0] port_b_pin_pullup_enable = 8'hf0, port_b_dir_input = 8'h3c;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] port_b_pullup_on;
  wire vector_load, push_return, return_from_service_instr;
  wire [15:0] vector_addr;
  integer n_mismatch = 0, n_tests = 0, n;
  reg [15:0] vq[$];
  reg [31:0] rv;
  reg [1:0] rr;
  prioritized_interrupt_control prioritized_interrupt_control_inst (.*);
  core_model core_model_inst (.*);
  always #50 aclk = ~aclk;
  always @(posedge aclk) if (vector_load === 1'h1) vq.push_back(vector_addr);
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge aclk);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      // Control registers change by single bus writes only
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do @(posedge aclk); while (s_axi_awready !== 1'h1);
      s_axi_awvalid <= 1'h0;
      s_axi_wvalid <= 1'h0;
      s_axi_bready <= 1'h1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input string nm);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(posedge aclk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'h0;
      chk(nm, e, rv);
    end
  endtask
  task tick_timer;
    begin
      timer_zero_overflow <= 1'h1;
      @(posedge aclk);
      timer_zero_overflow <= 1'h0;
    end
  endtask
  task t_regs;
    begin
      rd(`OFS_MAIN, 32'h00, "main");
      rd(`OFS_EDGE, 32'hf5, "edge");
      rd(`OFS_EXTP, 32'hc0, "extp");
      chk("pullup", 32'h0, port_b_pullup_on);
      wr(`OFS_EDGE, 32'hff);
      rd(`OFS_EDGE, 32'hf5, "edgemask");
      wr(`OFS_EXTP, 32'hff);
      rd(`OFS_EXTP, 32'hdb, "extpmask");
      wr(`OFS_EXTP, 32'hc0);
      // Pull-ups on and timer set to low priority for later scenarios
      wr(`OFS_EDGE, 32'h71);
      cyc(2);
      chk("pullup", 32'h30, port_b_pullup_on);
      rd(8'h18, 32'h0, "unmapped");
      chk("decerr", `RESP_DECERR, rr);
      $display("t_regs done");
    end
  endtask
  task t_flags;
    begin
      wr(`OFS_MAIN, 32'h30);
      tick_timer;
      ext_pin_zero <= 1'h1;
      cyc(6);
      rd(`OFS_MAIN, 32'h36, "flags");
      chk("blocked", 32'h0, vq.size());
      wr(`OFS_MAIN, 32'h00);
      ext_pin_zero <= 1'h0;
      cyc(6);
      rd(`OFS_MAIN, 32'h00, "falledge");
      $display("t_flags done");
    end
  endtask
  task t_compat;
    begin
      wr(`OFS_MAIN, 32'ha0);
      tick_timer;
      cyc(3);
      chk("vec", `VEC_HIGH, vq[0]);
      rd(`OFS_MAIN, 32'h24, "gieclr");
      wr(`OFS_MAIN, 32'h20); // Flag cleared before return
      cyc(45);
      rd(`OFS_MAIN, 32'ha0, "gieset");
      wr(`OFS_MAIN, 32'h90);
      ext_pin_zero <= 1'h1;
      n = 0;
      do begin
        @(posedge aclk);
        n = n + 1;
      end while (vector_load !== 1'h1 && n < 20);
      chk("latency", 32'h1, (n >= 5 && n <= 6));
      wr(`OFS_MAIN, 32'h10);
      cyc(45);
      wr(`OFS_MAIN, 32'h80);
      periph_pending <= 8'h01;
      cyc(5);
      chk("periph", 32'h2, vq.size());
      wr(`OFS_MAIN, 32'hc0);
      cyc(2);
      chk("periphgo", 32'h3, vq.size());
      periph_pending <= 8'h00;
      cyc(45);
      $display("t_compat done");
    end
  endtask
  task t_prio;
    begin
      // Pin 0 is left high earlier; bring it low so a rising edge can follow
      ext_pin_zero <= 1'h0;
      wr(`OFS_CTRL, 32'h01);
      wr(`OFS_MAIN, 32'hf0);
      vq.delete();
      tick_timer;
      cyc(4);
      ext_pin_zero <= 1'h1;
      cyc(8);
      wr(`OFS_MAIN, 32'h30);
      chk("low", `VEC_LOW, vq[0]);
      chk("preempt", `VEC_HIGH, vq[1]);
      cyc(100);
      wr(`OFS_MAIN, 32'h36);
      wr(`OFS_MAIN, 32'hf6);
      cyc(10);
      chk("first", `VEC_HIGH, vq[2]);
      chk("held", 32'h3, vq.size());
      wr(`OFS_MAIN, 32'h74);
      cyc(50);
      chk("after", `VEC_LOW, vq[3]);
      wr(`OFS_MAIN, 32'h00);
      cyc(50);
      $display("t_prio done");
    end
  endtask
  task t_port;
    begin
      cyc(50);
      wr(`OFS_MAIN, 32'h00);
      wr(`OFS_CTRL, 32'h0201);
      port_pins <= 8'h01;
      cyc(6);
      rd(`OFS_MAIN, 32'h00, "pcmask");
      port_pins <= 8'h03;
      cyc(6);
      rd(`OFS_MAIN, 32'h01, "pcflag");
      wr(`OFS_MAIN, 32'h00);
      rd(`OFS_MAIN, 32'h01, "pcpersist");
      rd(`OFS_PORT, 32'h03, "port");
      wr(`OFS_MAIN, 32'h00);
      rd(`OFS_MAIN, 32'h00, "pcclear");
      ext_pin_one <= 1'h1;
      cyc(6);
      rd(`OFS_EXTP, 32'hc1, "pin1flag");
      $display("t_port done");
    end
  endtask
  task report_and_stop;
    begin
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    #500000;
    n_mismatch = n_mismatch + 1;
    report_and_stop;
  end
  initial begin
    cyc(2);
    aresetn <= 1'h1;
    cyc(1);
    t_regs;
    t_flags;
    t_compat;
    t_prio;
    t_port;
    report_and_stop;
  end
endmodule // testbench
